// ### clk_ctrl_pkg.sv
// shared constants for the main clock controller
package clk_ctrl_pkg;

   // register indices as printed; byte address is four times the index
   localparam logic [7:0] CSR_IDX  = 8'h2c;
   localparam logic [7:0] TONE_IDX = 8'h2d;
   localparam logic [7:0] CSR_ADDR  = 8'(CSR_IDX << 2);
   localparam logic [7:0] TONE_ADDR = 8'(TONE_IDX << 2);

   // control/status and tone field positions
   localparam int CLK_OUT_EN_BIT = 7;
   localparam int SLOW_DIV_LSB   = 5;
   localparam int SLOW_MODE_BIT  = 4;
   localparam int TB_SEL_LSB     = 2;
   localparam int IRQ_EN_BIT     = 1;
   localparam int FLAG_BIT       = 0;
   localparam int BEEP_SEL_LSB   = 0;

   // reset values
   localparam logic [7:0] CSR_RST  = 8'h00;
   localparam logic [7:0] TONE_RST = 8'h00;

   // time base periods in oscillator cycles
   localparam int TB_PERIOD_0 = 16000;
   localparam int TB_PERIOD_1 = 32000;
   localparam int TB_PERIOD_2 = 80000;
   localparam int TB_PERIOD_3 = 200000;
   localparam int TB_CNT_W    = 18;

   // tone frequencies at the reference oscillator, half periods in cycles
   localparam int TONE_REF_OSC_HZ = 8000000;
   localparam int TONE_HZ_1       = 2000;
   localparam int TONE_HZ_2       = 1000;
   localparam int TONE_HZ_3       = 500;
   localparam int TONE_HALF_1     = TONE_REF_OSC_HZ / (2 * TONE_HZ_1);
   localparam int TONE_HALF_2     = TONE_REF_OSC_HZ / (2 * TONE_HZ_2);
   localparam int TONE_HALF_3     = TONE_REF_OSC_HZ / (2 * TONE_HZ_3);
   localparam int TONE_CNT_W      = 13;

   // processor power state as seen by this block
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_TIMED_SLEEP,
      PWR_FULL_HALT
   } pwr_state_t;

endpackage

// ### core_clk_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module core_clk_prescaler (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic       slow_mode,
   input  wire logic [1:0] div_sel,
   output logic            core_clk_en
);
   logic [3:0] cnt_r;
   logic [3:0] lim_r;
   logic [3:0] lim_nxt;

   // last count of one core period: 0 in normal mode, 1/3/7/15 when slow
   always_comb begin
      if (!slow_mode) begin
         lim_nxt = 4'h0;
      end else begin
         lim_nxt = 4'((4'h2 << div_sel) - 4'h1);
      end
   end

   // new setting is only taken at a period boundary, so no pulse is cut short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         lim_r <= 4'h0;
      end else if (run) begin
         if (cnt_r >= lim_r) begin
            cnt_r <= 4'h0;
            lim_r <= lim_nxt;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end

   assign core_clk_en = run && (cnt_r >= lim_r);
endmodule // core_clk_prescaler
`default_nettype wire

// ### tone_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tone_gen #(
   parameter int HALF_1 = 2000,
   parameter int HALF_2 = 4000,
   parameter int HALF_3 = 8000
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic [1:0] sel,
   output logic            tone_o
);
   import clk_ctrl_pkg::*;

   logic [TONE_CNT_W-1:0] cnt_r;
   logic [TONE_CNT_W-1:0] last;
   logic [1:0]            sel_r;

   // half period picks the pitch; equal halves give 50 percent duty
   always_comb begin
      case (sel)
         2'h1:    last = TONE_CNT_W'(HALF_1 - 1);
         2'h2:    last = TONE_CNT_W'(HALF_2 - 1);
         default: last = TONE_CNT_W'(HALF_3 - 1);
      endcase
   end

   // restart on a change of pitch; frozen while halted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r  <= '0;
         sel_r  <= 2'h0;
         tone_o <= 1'b0;
      end else if (run) begin
         sel_r <= sel;
         if (sel == 2'h0 || sel != sel_r) begin
            cnt_r  <= '0;
            tone_o <= 1'b0;
         end else if (cnt_r >= last) begin
            cnt_r  <= '0;
            tone_o <= ~tone_o;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule // tone_gen
`default_nettype wire

// ### clock_prescaler_rtc_beeper.sv
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler_rtc_beeper #(
   parameter int TB_PER_0  = clk_ctrl_pkg::TB_PERIOD_0,
   parameter int TB_PER_1  = clk_ctrl_pkg::TB_PERIOD_1,
   parameter int TB_PER_2  = clk_ctrl_pkg::TB_PERIOD_2,
   parameter int TB_PER_3  = clk_ctrl_pkg::TB_PERIOD_3,
   parameter int TONE_H_1  = clk_ctrl_pkg::TONE_HALF_1,
   parameter int TONE_H_2  = clk_ctrl_pkg::TONE_HALF_2,
   parameter int TONE_H_3  = clk_ctrl_pkg::TONE_HALF_3
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // processor power control, same clock domain
   input  wire logic        halt_req,
   input  wire logic        wake_irq,
   output logic             core_clk_en,
   output logic             tick_irq,
   output logic             timed_sleep,
   output logic             full_halt,
   // port logic for the two shared pins
   input  wire logic        gpio0_out,
   input  wire logic        gpio0_oe,
   input  wire logic        gpio1_out,
   input  wire logic        gpio1_oe,
   output logic             clock_out_pin_out,
   output logic             clock_out_pin_oe,
   output logic             tone_pin_out,
   output logic             tone_pin_oe
);
   import clk_ctrl_pkg::*;

   // control/status fields
   logic                clk_out_en_r;
   logic [1:0]          slow_div_r;
   logic                slow_mode_r;
   logic [1:0]          tb_sel_r;
   logic                irq_en_r;
   logic                tick_flag_r;
   // tone control field
   logic [1:0]          beep_sel_r;
   // time base
   logic [1:0]          tb_act_r;
   logic [TB_CNT_W-1:0] tb_cnt_r;
   logic                tb_end;
   logic                tb_run;
   // power state
   pwr_state_t          pwr_r;
   pwr_state_t          pwr_nxt;
   logic                cpu_run;
   // bus decode
   logic                setup_ph;
   logic                access_ph;
   logic                hit_csr;
   logic                hit_tone;
   logic                wr_csr;
   logic                wr_tone;
   logic                rd_clear;
   logic [7:0]          csr_val;
   logic [31:0]         prdata_r;
   // pin side
   logic                clk_out_r;
   logic                tone_wave;
   logic                clk_out_go;

   // last count of a period for a given selection
   function automatic logic [TB_CNT_W-1:0] tb_last(input logic [1:0] sel);
      case (sel)
         2'h0:    tb_last = TB_CNT_W'(TB_PER_0 - 1);
         2'h1:    tb_last = TB_CNT_W'(TB_PER_1 - 1);
         2'h2:    tb_last = TB_CNT_W'(TB_PER_2 - 1);
         default: tb_last = TB_CNT_W'(TB_PER_3 - 1);
      endcase
   endfunction

   // apb phases and address decode; unmapped offsets answer with an error
   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign hit_csr   = (paddr == CSR_ADDR);
   assign hit_tone  = (paddr == TONE_ADDR);
   assign cpu_run   = (pwr_r == PWR_RUN);

   // registers only change while the processor runs
   assign wr_csr   = access_ph && pwrite && hit_csr && cpu_run;
   assign wr_tone  = access_ph && pwrite && hit_tone && cpu_run;
   assign rd_clear = access_ph && !pwrite && hit_csr && cpu_run;

   // zero wait states: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign pslverr = access_ph && !(hit_csr || hit_tone);
   assign prdata  = prdata_r;

   // status image as software sees it
   assign csr_val = {clk_out_en_r, slow_div_r, slow_mode_r,
                     tb_sel_r, irq_en_r, tick_flag_r};

   // word image of a register; reserved and unmapped bits read 0
   function automatic logic [31:0] read_word(input logic       csr_sel,
                                             input logic       tone_sel,
                                             input logic [7:0] csr_img,
                                             input logic [1:0] tone_img);
      if (csr_sel) begin
         read_word = {24'h00_0000, csr_img};
      end else if (tone_sel) begin
         read_word = {30'h0000_0000, tone_img};
      end else begin
         read_word = 32'h0000_0000;
      end
   endfunction

   // read data is captured in the setup cycle so it comes from a flop;
   // the flag value returned is the one seen in the setup cycle; a tick at that edge is cleared by the access unread
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_r <= read_word(hit_csr, hit_tone, csr_val, beep_sel_r);
      end
   end

   // software fields of the control/status register; bit 0 is not writable
   // clock out selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_out_en_r <= CSR_RST[CLK_OUT_EN_BIT];
      end else if (wr_csr) begin
         clk_out_en_r <= pwdata[CLK_OUT_EN_BIT];
      end
   end

   // slow divider selection, ignored while slow mode is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_div_r <= CSR_RST[SLOW_DIV_LSB +: 2];
      end else if (wr_csr) begin
         slow_div_r <= pwdata[SLOW_DIV_LSB +: 2];
      end
   end

   // slow mode selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_mode_r <= CSR_RST[SLOW_MODE_BIT];
      end else if (wr_csr) begin
         slow_mode_r <= pwdata[SLOW_MODE_BIT];
      end
   end

   // time base selection; the counter only picks it up at a period end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tb_sel_r <= CSR_RST[TB_SEL_LSB +: 2];
      end else if (wr_csr) begin
         tb_sel_r <= pwdata[TB_SEL_LSB +: 2];
      end
   end

   // tick interrupt enable, also picks timed sleep over full halt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_r <= CSR_RST[IRQ_EN_BIT];
      end else if (wr_csr) begin
         irq_en_r <= pwdata[IRQ_EN_BIT];
      end
   end

   // tone control; upper bits are not stored, software keeps them at zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         beep_sel_r <= TONE_RST[BEEP_SEL_LSB +: 2];
      end else if (wr_tone) begin
         beep_sel_r <= pwdata[BEEP_SEL_LSB +: 2];
      end
   end

   // time base runs except in full halt, including through timed sleep
   assign tb_run = (pwr_r != PWR_FULL_HALT);
   assign tb_end = tb_run && (tb_cnt_r >= tb_last(tb_act_r));

   // period counter restarts by itself, no software reload needed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tb_cnt_r <= '0;
      end else if (tb_end) begin
         tb_cnt_r <= '0;
      end else if (tb_run) begin
         tb_cnt_r <= tb_cnt_r + 1'b1;
      end
   end

   // the active selection is reloaded only when a period ends, so a write
   // never stretches or cuts the period in progress
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tb_act_r <= CSR_RST[TB_SEL_LSB +: 2];
      end else if (tb_end) begin
         tb_act_r <= tb_sel_r;
      end
   end

   // flag: a period end in the same cycle as a clearing read keeps it set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_flag_r <= CSR_RST[FLAG_BIT];
      end else if (tb_end) begin
         tick_flag_r <= 1'b1;
      end else if (rd_clear) begin
         tick_flag_r <= 1'b0;
      end
   end

   // level request; the processor applies its own global mask
   assign tick_irq = tick_flag_r && irq_en_r;

   // power state: halt chooses timed sleep or full halt from the enable
   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         PWR_RUN: begin
            if (halt_req) begin
               if (irq_en_r) begin
                  pwr_nxt = PWR_TIMED_SLEEP;
               end else begin
                  pwr_nxt = PWR_FULL_HALT;
               end
            end
         end
         PWR_TIMED_SLEEP: begin
            if (tick_irq || wake_irq) begin
               pwr_nxt = PWR_RUN;
            end
         end
         PWR_FULL_HALT: begin
            if (wake_irq) begin
               pwr_nxt = PWR_RUN;
            end
         end
         default: begin
            pwr_nxt = PWR_RUN;
         end
      endcase
   end

   // power state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_r <= PWR_RUN;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   assign timed_sleep = (pwr_r == PWR_TIMED_SLEEP);
   assign full_halt   = (pwr_r == PWR_FULL_HALT);

   // core clock enable; stopped outside run so the core stays frozen
   core_clk_prescaler u_prescaler (
      .pclk        (pclk),
      .presetn     (presetn),
      .run         (cpu_run),
      .slow_mode   (slow_mode_r),
      .div_sel     (slow_div_r),
      .core_clk_en (core_clk_en)
   );

   // looks one state ahead so the pin is already low in the first sleep cycle
   assign clk_out_go = clk_out_en_r && (pwr_nxt == PWR_RUN);

   // clock out: oscillator divided by two, since a flop cannot copy the
   // oscillator itself; held low outside run to save power
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_out_r <= 1'b0;
      end else if (clk_out_go) begin
         clk_out_r <= ~clk_out_r;
      end else begin
         clk_out_r <= 1'b0;
      end
   end

   // pin 0: alternate function or port logic
   always_comb begin
      if (clk_out_en_r) begin
         clock_out_pin_out = clk_out_r;
         clock_out_pin_oe  = 1'b1;
      end else begin
         clock_out_pin_out = gpio0_out;
         clock_out_pin_oe  = gpio0_oe;
      end
   end

   // tone keeps going in timed sleep, frozen only in full halt
   tone_gen #(
      .HALF_1 (TONE_H_1),
      .HALF_2 (TONE_H_2),
      .HALF_3 (TONE_H_3)
   ) u_tone (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (tb_run),
      .sel     (beep_sel_r),
      .tone_o  (tone_wave)
   );

   // pin 1: tone takes the pin whenever a pitch is selected
   always_comb begin
      if (beep_sel_r != 2'h0) begin
         tone_pin_out = tone_wave;
         tone_pin_oe  = 1'b1;
      end else begin
         tone_pin_out = gpio1_out;
         tone_pin_oe  = gpio1_oe;
      end
   end

endmodule // clock_prescaler_rtc_beeper
`default_nettype wire

// ### clock_prescaler_rtc_beeper_props.sv
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler_rtc_beeper_props
   import clk_ctrl_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic        halt_req,
   input wire logic        wake_irq,
   input wire logic        core_clk_en,
   input wire logic        tick_irq,
   input wire logic        timed_sleep,
   input wire logic        full_halt,
   input wire logic        gpio0_out,
   input wire logic        gpio0_oe,
   input wire logic        clock_out_pin_out,
   input wire logic        clock_out_pin_oe,
   input wire logic        tone_pin_oe
);
   logic       run;
   logic       acc;
   logic [7:0] csr_r;
   logic [1:0] tone_r;
   logic [4:0] norm_cnt_r;
   assign run = !timed_sleep && !full_halt;
   assign acc = psel && penable && pwrite && run;
   // shadow of the writable fields; writes outside run are dropped like the real ones
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csr_r <= 8'h00;
         tone_r <= 2'h0;
      end else if (acc) begin
         if (paddr == CSR_ADDR)
            csr_r <= pwdata[7:0] & 8'hfe;
         if (paddr == TONE_ADDR)
            tone_r <= pwdata[1:0];
      end
   end
   // run cycles since slow mode went off; a slow period may still be finishing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         norm_cnt_r <= 5'h00;
      end else if (csr_r[4]) begin
         norm_cnt_r <= 5'h00;
      end else if (run && norm_cnt_r != 5'h10) begin
         norm_cnt_r <= norm_cnt_r + 5'h01;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   normal_speed_a: assert property (run && !csr_r[4] && norm_cnt_r == 5'h10 |-> core_clk_en)
      else $error("core clock gated in normal mode");
   held_core_a: assert property (!run |-> !core_clk_en)
      else $error("core clock runs outside run state");
   slow_gap_a: assert property (run && $past(run) && csr_r[4] && $past(csr_r[4])
      && $past(csr_r[4], 2) && core_clk_en |=> !core_clk_en) else $error("slow pulses adjacent");
   clkout_own_a: assert property (csr_r[7] |-> clock_out_pin_oe)
      else $error("clock out pin not driven");
   gpio0_pass_a: assert property (!csr_r[7] |-> clock_out_pin_oe == gpio0_oe
      && clock_out_pin_out == gpio0_out) else $error("pin not returned to port logic");
   clkout_toggle_a: assert property (run && $past(run) && $past(run, 2) && csr_r[7]
      && $past(csr_r[7]) |-> clock_out_pin_out != $past(clock_out_pin_out))
      else $error("clock out not toggling");
   clkout_stop_a: assert property (timed_sleep && csr_r[7] |-> !clock_out_pin_out)
      else $error("clock out active in timed sleep");
   irq_gate_a: assert property (tick_irq |-> csr_r[1])
      else $error("interrupt while disabled");
   sleep_entry_a: assert property (halt_req && run |=> (csr_r[1] ? timed_sleep : full_halt))
      else $error("wrong halt state");
   tick_wake_a: assert property (timed_sleep && tick_irq |=> !timed_sleep)
      else $error("tick did not wake timed sleep");
   halt_hold_a: assert property (full_halt && !wake_irq |=> full_halt)
      else $error("full halt left without wake");
   tone_own_a: assert property (tone_r != 2'h0 |-> tone_pin_oe)
      else $error("tone pin not driven");
   bad_addr_a: assert property (psel && penable && paddr != CSR_ADDR && paddr != TONE_ADDR
      |-> pslverr) else $error("unmapped access without error");
endmodule // clock_prescaler_rtc_beeper_props
bind clock_prescaler_rtc_beeper clock_prescaler_rtc_beeper_props i_props (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .halt_req, .wake_irq,
   .core_clk_en, .tick_irq, .timed_sleep, .full_halt, .gpio0_out, .gpio0_oe,
   .clock_out_pin_out, .clock_out_pin_oe, .tone_pin_oe);
`default_nettype wire

// ### test_clock_prescaler_rtc_beeper.sv
`timescale 1ns/1ps
`default_nettype none
module test_clock_prescaler_rtc_beeper;
   import clk_ctrl_pkg::*;
   localparam int TBP [4] = '{20, 30, 40, 50};
   localparam int THP [4] = '{0, 3, 4, 5};
   logic        pclk, presetn, psel, penable, pwrite, halt_req, wake_irq, v;
   logic        gpio0_out, gpio0_oe, gpio1_out, gpio1_oe, pready, pslverr;
   logic        core_clk_en, tick_irq, timed_sleep, full_halt;
   logic        clock_out_pin_out, clock_out_pin_oe, tone_pin_out, tone_pin_oe;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic [31:0] exp_q[$];
   logic        err_q[$];
   int          fail_count, checks, n;
   time         t0;
   // short periods keep the run brief; the time base and tone expectations use these tables
   clock_prescaler_rtc_beeper #(.TB_PER_0(TBP[0]), .TB_PER_1(TBP[1]), .TB_PER_2(TBP[2]),
      .TB_PER_3(TBP[3]), .TONE_H_1(THP[1]), .TONE_H_2(THP[2]), .TONE_H_3(THP[3]))
   i_clock_prescaler_rtc_beeper (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .halt_req, .wake_irq, .core_clk_en, .tick_irq, .timed_sleep,
      .full_halt, .gpio0_out, .gpio0_oe, .gpio1_out, .gpio1_oe, .clock_out_pin_out,
      .clock_out_pin_oe, .tone_pin_out, .tone_pin_oe);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one apb transfer; the note goes on the queue before the request starts
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic er);
      err_q.push_back(er);
      if (!wr && !er)
         exp_q.push_back(d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wr ? d : 32'h0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // the watcher pairs every completed access with the oldest note
   always @(posedge pclk) begin
      logic e;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         e = err_q.pop_front();
         check({31'h0, pslverr}, {31'h0, e});
         if (!pwrite && !e)
            check(prdata, exp_q.pop_front());
      end
   end
   // port logic noise on the shared pins
   always @(posedge pclk)
      {gpio0_out, gpio0_oe, gpio1_out, gpio1_oe} <= 4'($urandom);
   task automatic wait_tick();
      @(posedge pclk);
      while (tick_irq !== 1'b1)
         @(posedge pclk);
   endtask
   // a stale flag may be pending, so two rounds leave the next period clean;
   // t0 marks the last flag seen, so a period is timed flag to flag
   task automatic sync_tick(input logic [7:0] cfg);
      repeat (2) begin
         wait_tick();
         t0 = $time;
         apb(1'b0, CSR_ADDR, {24'h0, cfg | 8'h01}, 1'b0);
      end
   endtask
   task automatic wait_tone();
      v = tone_pin_out;
      @(posedge pclk);
      while (tone_pin_out === v)
         @(posedge pclk);
   endtask
   initial begin
      #100us;
      fail_count++;
      conclude();
   end
   initial begin
      {presetn, psel, penable, pwrite, halt_req, wake_irq} = 6'h0;
      {gpio0_out, gpio0_oe, gpio1_out, gpio1_oe} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      void'($urandom(35821));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, CSR_ADDR, 32'h0, 1'b0);
      apb(1'b0, TONE_ADDR, 32'h0, 1'b0);
      apb(1'b0, 8'h00, 32'h0, 1'b1);
      apb(1'b1, 8'hb8, 32'h5, 1'b1);
      rnd = $urandom & 32'h3;
      apb(1'b1, TONE_ADDR, rnd, 1'b0);
      apb(1'b0, TONE_ADDR, rnd, 1'b0);
      // each time base: period measured between two flag events
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, CSR_ADDR, 32'(8'h02 | (s << 2)), 1'b0);
         sync_tick(8'(8'h02 | (s << 2)));
         wait_tick();
         check(32'(($time - t0) / 10), 32'(TBP[s]));
         apb(1'b0, CSR_ADDR, 32'(8'h03 | (s << 2)), 1'b0);
      end
      apb(1'b1, CSR_ADDR, 32'h01, 1'b0);
      apb(1'b0, CSR_ADDR, 32'h00, 1'b0);
      // core clock rate: four slow settings and normal mode
      for (int d = 0; d < 5; d++) begin
         apb(1'b1, CSR_ADDR, (d < 4) ? 32'(8'h10 | (d << 5)) : 32'h0, 1'b0);
         repeat (20) @(posedge pclk);
         n = 0;
         repeat (64) begin
            @(posedge pclk);
            n += int'(core_clk_en === 1'b1);
         end
         check(32'(n), (d < 4) ? 32'(64 >> (d + 1)) : 32'd64);
      end
      apb(1'b1, CSR_ADDR, 32'h80, 1'b0);
      repeat (4) begin
         v = clock_out_pin_out;
         @(posedge pclk);
         check({31'h0, clock_out_pin_out}, {31'h0, ~v});
      end
      for (int s = 1; s < 4; s++) begin
         apb(1'b1, TONE_ADDR, 32'(s), 1'b0);
         wait_tone();
         t0 = $time;
         wait_tone();
         check(32'(($time - t0) / 10), 32'(THP[s]));
      end
      // timed sleep: registers frozen, tick wakes
      apb(1'b1, CSR_ADDR, 32'h8e, 1'b0);
      sync_tick(8'h8e);
      halt_req <= 1'b1;
      @(posedge pclk);
      halt_req <= 1'b0;
      @(posedge pclk);
      check({31'h0, timed_sleep}, 32'h1);
      apb(1'b1, TONE_ADDR, 32'h0, 1'b0);
      for (n = 0; n < 200 && timed_sleep === 1'b1; n++)
         @(posedge pclk);
      check({31'h0, timed_sleep}, 32'h0);
      apb(1'b0, TONE_ADDR, 32'h3, 1'b0);
      // full halt: only the wake input ends it
      apb(1'b1, CSR_ADDR, 32'h00, 1'b0);
      halt_req <= 1'b1;
      @(posedge pclk);
      halt_req <= 1'b0;
      repeat (120) @(posedge pclk);
      check({31'h0, full_halt}, 32'h1);
      wake_irq <= 1'b1;
      @(posedge pclk);
      wake_irq <= 1'b0;
      @(posedge pclk);
      check({31'h0, full_halt}, 32'h0);
      // second reset in mid-run: flag and tone pitch are checked to read back zero
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, CSR_ADDR, 32'h0, 1'b0);
      apb(1'b0, TONE_ADDR, 32'h0, 1'b0);
      conclude();
   end
endmodule // test_clock_prescaler_rtc_beeper
`default_nettype wire
